// ==== verilog/gain_port_regs.svh ====
// Register offsets, fields, reset values and sizes of the gain control port
`ifndef GAIN_PORT_REGS_SVH
`define GAIN_PORT_REGS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define GP_CTRL_OFS     12'h000
`define GP_GAIN_OFS     12'h004
`define GP_STATUS_OFS   12'h008
`define GP_SHIFT_OFS    12'h00C

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define GP_CTRL_TRANSMIT_ENABLE_BIT    0
`define GP_CTRL_SLEEPN_BIT  1
`define GP_STAT_TXON_BIT    0
`define GP_STAT_AWAKE_BIT   1
`define GP_STAT_LOADING_BIT 2
`define GP_STAT_UPD_BIT     3

// ---------------------------------------------------------------
// Reset values and sizes
// ---------------------------------------------------------------
`define GP_CTRL_RESET   2'h0
`define GP_GAIN_RESET   7'h00
`define GP_WORD_BITS    8
`define GP_CORE_BITS    7
`define GP_MAX_LIN_CODE 7'h47

`endif

// ==== verilog/gain_port_pkg.sv ====
// Types shared by the gain control port modules
package gain_port_pkg;
  typedef logic [6:0] core_code_t;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } load_state_t;
endpackage

// ==== verilog/pin_sync_if.sv ====
// Synchronised link pins passed from the pin sampler to the core
`timescale 1ns/1ps
interface pin_sync_if;
  logic clk_rise;
  logic clk_fall;
  logic data;
  logic strobe_rise;
  logic strobe_fall;
  logic strobe_n;
  modport src (output clk_rise, clk_fall, data, strobe_rise, strobe_fall, strobe_n);
  modport dst (input clk_rise, clk_fall, data, strobe_rise, strobe_fall, strobe_n);
endinterface

// ==== verilog/pin_sampler.sv ====
// Two-stage synchronisers and edge detection for the serial link pins
`timescale 1ns/1ps
module pin_sampler (
  // Clock and reset
  input  wire logic  ref_clk_in,
  input  wire logic  reset_n_in,
  // Raw pins
  input  wire logic  serial_clk_in,
  input  wire logic  serial_gain_in,
  input  wire logic  load_strobe_n_in,
  // Synchronised view
  pin_sync_if.src    sync
);
  logic [2:0] meta_reg;
  logic [2:0] meta_next;
  logic [2:0] stab_reg;
  logic [2:0] stab_next;
  logic [1:0] prev_reg;
  logic [1:0] prev_next;

  always_comb begin
    meta_next = {serial_clk_in, serial_gain_in, load_strobe_n_in};
    stab_next = meta_reg;
    prev_next = {stab_reg[2], stab_reg[0]};
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      // Idle pin levels: serial clock low, data low, strobe high
      meta_reg <= 3'h1;
      stab_reg <= 3'h1;
      prev_reg <= 2'h1;
    end else begin
      meta_reg <= meta_next;
      stab_reg <= stab_next;
      prev_reg <= prev_next;
    end
  end

  // Data is read from the stable stage, aligned with the clock edge flags
  assign sync.data        = stab_reg[1];
  assign sync.strobe_n    = stab_reg[0];
  assign sync.clk_rise    = stab_reg[2] & ~prev_reg[1];
  assign sync.clk_fall    = ~stab_reg[2] & prev_reg[1];
  assign sync.strobe_rise = stab_reg[0] & ~prev_reg[0];
  assign sync.strobe_fall = ~stab_reg[0] & prev_reg[0];
endmodule

// ==== verilog/serial_gain_control_port.sv ====
// Serial gain control port with AHB-Lite register access
//
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "gain_port_regs.svh"
module serial_gain_control_port
  import gain_port_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hwdata_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // Serial link
  input  wire logic        serial_clk_in,
  input  wire logic        serial_gain_in,
  input  wire logic        load_strobe_n_in,
  // Attenuator core and power control
  output logic      [6:0]  gain_code_out,
  output logic             tx_power_on_out,
  output logic             awake_out,
  output logic             out_hiz_out
);
  // ---------------------------------------------------------------
  // Link pin synchronisers
  // ---------------------------------------------------------------
  pin_sync_if sync ();

  pin_sampler u_sampler (
    .ref_clk_in       (ref_clk_in),
    .reset_n_in       (reset_n_in),
    .serial_clk_in    (serial_clk_in),
    .serial_gain_in   (serial_gain_in),
    .load_strobe_n_in (load_strobe_n_in),
    .sync             (sync)
  );

  // ---------------------------------------------------------------
  // Register bus state
  // ---------------------------------------------------------------
  logic        wr_pend_reg;
  logic        wr_pend_next;
  logic [11:0] wr_addr_reg;
  logic [11:0] wr_addr_next;
  logic [1:0]  ctrl_reg;
  logic [1:0]  ctrl_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        reg_wr;
  logic        addr_phase;

  // ---------------------------------------------------------------
  // Serial shift register and gain latch
  // ---------------------------------------------------------------
  load_state_t state_reg;
  load_state_t state_next;
  core_code_t  slave_reg;
  core_code_t  slave_next;
  logic        master_reg;
  logic        master_next;
  core_code_t  gain_reg;
  core_code_t  gain_next;
  logic        upd_reg;
  logic        upd_next;

  always_comb begin
    state_next  = state_reg;
    slave_next  = slave_reg;
    master_next = master_reg;
    gain_next   = gain_reg;
    upd_next    = upd_reg;
    case (state_reg)
      ST_IDLE: begin
        if (sync.strobe_fall) begin
          state_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (sync.strobe_rise) begin
          gain_next  = slave_reg;
          upd_next   = 1'b1;
          state_next = ST_IDLE;
        end else begin
          if (sync.clk_rise) begin
            master_next = sync.data;
          end
          if (sync.clk_fall) begin
            // Seven-bit slave: the oldest bit drops off the top
            slave_next = {slave_reg[5:0], master_reg};
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // Software clear of the update flag; a load in the same cycle wins
    if (reg_wr && wr_addr_reg == `GP_STATUS_OFS && hwdata_in[`GP_STAT_UPD_BIT]
        && !(state_reg == ST_SHIFT && sync.strobe_rise)) begin
      upd_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg  <= ST_IDLE;
      slave_reg  <= `GP_GAIN_RESET;
      master_reg <= 1'b0;
      gain_reg   <= `GP_GAIN_RESET;
      upd_reg    <= 1'b0;
    end else begin
      state_reg  <= state_next;
      slave_reg  <= slave_next;
      master_reg <= master_next;
      gain_reg   <= gain_next;
      upd_reg    <= upd_next;
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ---------------------------------------------------------------
  // Address phase accepted when selected, ready and NONSEQ or SEQ
  assign addr_phase = hsel_in & hready_in & htrans_in[1];
  assign reg_wr     = wr_pend_reg;

  always_comb begin
    wr_pend_next = addr_phase & hwrite_in;
    wr_addr_next = addr_phase ? haddr_in[11:0] : wr_addr_reg;
    ctrl_next    = ctrl_reg;
    rdata_next   = 32'h0000_0000;
    if (reg_wr && wr_addr_reg == `GP_CTRL_OFS) begin
      ctrl_next = hwdata_in[1:0];
    end
    if (addr_phase && !hwrite_in) begin
      if (haddr_in[11:0] == `GP_CTRL_OFS) begin
        rdata_next = {30'h0, ctrl_reg};
      end else if (haddr_in[11:0] == `GP_GAIN_OFS) begin
        rdata_next = {25'h0, gain_reg};
      end else if (haddr_in[11:0] == `GP_STATUS_OFS) begin
        rdata_next = {28'h0, upd_reg, state_reg == ST_SHIFT,
                      ctrl_reg[`GP_CTRL_SLEEPN_BIT],
                      ctrl_reg[`GP_CTRL_TRANSMIT_ENABLE_BIT] & ctrl_reg[`GP_CTRL_SLEEPN_BIT]};
      end else if (haddr_in[11:0] == `GP_SHIFT_OFS) begin
        rdata_next = {25'h0, slave_reg};
      end else begin
        rdata_next = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
      ctrl_reg    <= `GP_CTRL_RESET;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      ctrl_reg    <= ctrl_next;
      rdata_reg   <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  logic [6:0] gain_o_reg;
  logic [6:0] gain_o_next;
  logic       tx_o_reg;
  logic       tx_o_next;
  logic       awake_o_reg;
  logic       awake_o_next;
  logic       hiz_o_reg;
  logic       hiz_o_next;

  // Power pins follow the control register; transmit needs the part awake
  always_comb begin
    gain_o_next  = gain_reg;
    tx_o_next    = ctrl_reg[`GP_CTRL_TRANSMIT_ENABLE_BIT] & ctrl_reg[`GP_CTRL_SLEEPN_BIT];
    awake_o_next = ctrl_reg[`GP_CTRL_SLEEPN_BIT];
    hiz_o_next   = ~ctrl_reg[`GP_CTRL_SLEEPN_BIT];
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gain_o_reg  <= `GP_GAIN_RESET;
      tx_o_reg    <= 1'b0;
      awake_o_reg <= 1'b0;
      hiz_o_reg   <= 1'b1;
    end else begin
      gain_o_reg  <= gain_o_next;
      tx_o_reg    <= tx_o_next;
      awake_o_reg <= awake_o_next;
      hiz_o_reg   <= hiz_o_next;
    end
  end

  assign gain_code_out   = gain_o_reg;
  assign tx_power_on_out = tx_o_reg;
  assign awake_out       = awake_o_reg;
  assign out_hiz_out     = hiz_o_reg;
  assign hrdata_out      = rdata_reg;
  assign hreadyout_out   = 1'b1;
  assign hresp_out       = 1'b0;
endmodule

// ==== test/host_link_model.sv ====
// Host controller model driving the serial gain link
`timescale 1ns/1ps
module host_link_model (
  // Bench clock
  input  wire logic clk_in,
  // Serial link pins
  output logic      serial_clk_out,
  output logic      serial_gain_out,
  output logic      load_strobe_n_out
);
  initial begin
    serial_clk_out    = 1'b0;
    serial_gain_out   = 1'b0;
    load_strobe_n_out = 1'b1;
  end

  // One whole frame, eight bits MSB first; 160 ns serial clock period
  task automatic send(input logic [7:0] word);
    load_strobe_n_out <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      repeat (2) @(posedge clk_in);
      serial_gain_out <= word[i];
      repeat (6) @(posedge clk_in);
      serial_clk_out <= 1'b1;
      repeat (8) @(posedge clk_in);
      serial_clk_out <= 1'b0;
    end
    // Released data shows the inverse of the last bit
    repeat (2) @(posedge clk_in);
    serial_gain_out <= ~word[0];
    repeat (6) @(posedge clk_in);
    load_strobe_n_out <= 1'b1;
    repeat (8) @(posedge clk_in);
  endtask

  // Clocks sent while the strobe is high
  task automatic stray(input int n);
    repeat (n) begin
      serial_gain_out <= ~serial_gain_out;
      repeat (8) @(posedge clk_in);
      serial_clk_out <= 1'b1;
      repeat (8) @(posedge clk_in);
      serial_clk_out <= 1'b0;
    end
  endtask
endmodule

// ==== test/serial_gain_control_port_monitor.sv ====
// Concurrent checks on the gain control port pins
`timescale 1ns/1ps
module serial_gain_control_port_monitor (
  input wire logic        ref_clk_in,
  input wire logic        reset_n_in,
  input wire logic        hsel_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic        hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic        serial_clk_in,
  input wire logic        serial_gain_in,
  input wire logic        load_strobe_n_in,
  input wire logic [6:0]  gain_code_out,
  input wire logic        tx_power_on_out,
  input wire logic        awake_out,
  input wire logic        out_hiz_out
);
  logic       sclk_q_reg, sclk_q_next;
  logic [6:0] shadow_reg, shadow_next;
  wire logic  bus_wr = hsel_in && hwrite_in && htrans_in[1];

  // Reference copy of the seven kept bits
  always_comb begin
    sclk_q_next = serial_clk_in;
    shadow_next = shadow_reg;
    if (!load_strobe_n_in && serial_clk_in && !sclk_q_reg) begin
      shadow_next = {shadow_reg[5:0], serial_gain_in};
    end
  end
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sclk_q_reg <= 1'b0;
      shadow_reg <= 7'h00;
    end else begin
      sclk_q_reg <= sclk_q_next;
      shadow_reg <= shadow_next;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence strobe_rise;
    !load_strobe_n_in ##1 load_strobe_n_in;
  endsequence

  chk_gain_update: assert property (strobe_rise |-> ##[2:6] gain_code_out == shadow_reg)
    else $error("gain not loaded from shifted word");
  chk_gain_hold: assert property ((!load_strobe_n_in)[*8] |-> $stable(gain_code_out))
    else $error("gain moved while shifting");
  chk_gain_settle: assert property (load_strobe_n_in[*8] |-> $stable(gain_code_out))
    else $error("gain moved without a load");
  chk_hiz_awake: assert property (out_hiz_out == !awake_out)
    else $error("high impedance not tied to sleep");
  chk_tx_awake: assert property (tx_power_on_out |-> awake_out)
    else $error("transmit on while asleep");
  chk_pwr_cause: assert property ($changed({awake_out, tx_power_on_out}) |->
    $past(bus_wr, 2) || $past(bus_wr, 3) || $past(bus_wr, 4))
    else $error("power state changed without a write");
  chk_bus_okay: assert property (hreadyout_out && !hresp_out)
    else $error("bus answer not ready and okay");
  chk_idle_rdata: assert property (!(hsel_in && hready_in && htrans_in[1] && !hwrite_in)
    |=> hrdata_out == 32'h0)
    else $error("read data without a read");
endmodule

bind serial_gain_control_port serial_gain_control_port_monitor mon (.ref_clk_in, .reset_n_in,
  .hsel_in, .htrans_in, .hwrite_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out,
  .serial_clk_in, .serial_gain_in, .load_strobe_n_in, .gain_code_out, .tx_power_on_out,
  .awake_out, .out_hiz_out);

// ==== test/tb.sv ====
// Self-checking bench for the serial gain control port
`timescale 1ns/1ps
`include "gain_port_regs.svh"
module tb;
  logic ref_clk_in, reset_n_in, hsel, hwrite, hreadyout, hresp, tx, awake, hiz;
  logic sclk, sdat, strobe_n;
  logic [1:0]  htrans;
  logic [6:0]  gain;
  logic [31:0] haddr, hwdata, hrdata, d;
  int          mismatches, n_tests, cycles;

  serial_gain_control_port dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'h2), .hready_in(hreadyout), .hwdata_in(hwdata), .hrdata_out(hrdata),
    .hreadyout_out(hreadyout), .hresp_out(hresp), .serial_clk_in(sclk),
    .serial_gain_in(sdat), .load_strobe_n_in(strobe_n), .gain_code_out(gain),
    .tx_power_on_out(tx), .awake_out(awake), .out_hiz_out(hiz));
  host_link_model host (.clk_in(ref_clk_in), .serial_clk_out(sclk), .serial_gain_out(sdat),
    .load_strobe_n_out(strobe_n));

  always #5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pins(input logic [6:0] g, input logic t, input logic a, input logic h);
    check({22'h0, gain, tx, awake, hiz}, {22'h0, g, t, a, h});
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge ref_clk_in);
    while (hreadyout !== 1'b1) @(posedge ref_clk_in);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge ref_clk_in);
    while (hreadyout !== 1'b1) @(posedge ref_clk_in);
    d = hrdata;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(d, exp);
  endtask

  task automatic t_reset();
    pins(7'h00, 1'b0, 1'b0, 1'b1);
    rd(`GP_CTRL_OFS, 32'h0);
    rd(12'h010, 32'h0);
  endtask
  task automatic t_power();
    logic [1:0] c;
    for (int v = 0; v < 4; v++) begin
      c = v[1:0];
      bus(1'b1, `GP_CTRL_OFS, {30'h0, c});
      repeat (4) @(posedge ref_clk_in);
      pins(7'h00, &c, c[1], ~c[1]);
      rd(`GP_STATUS_OFS, {30'h0, c[1], &c});
    end
  endtask
  task automatic t_load();
    logic [7:0] w [6] = '{8'h47, 8'hC7, 8'hFF, 8'h00, 8'h80, 8'h5A};
    foreach (w[i]) begin
      host.send(w[i]);
      repeat (8) @(posedge ref_clk_in);
      pins(w[i][6:0], 1'b1, 1'b1, 1'b0);
      rd(`GP_GAIN_OFS, {25'h0, w[i][6:0]});
      rd(`GP_STATUS_OFS, 32'hB);
      bus(1'b1, `GP_STATUS_OFS, 32'h8);
      rd(`GP_STATUS_OFS, 32'h3);
    end
  endtask
  task automatic t_stray();
    host.stray(8);
    repeat (8) @(posedge ref_clk_in);
    pins(7'h5A, 1'b1, 1'b1, 1'b0);
    rd(`GP_SHIFT_OFS, 32'h5A);
    fork
      host.send(8'h91);
      begin
        repeat (100) @(posedge ref_clk_in);
        pins(7'h5A, 1'b1, 1'b1, 1'b0);
        rd(`GP_SHIFT_OFS, 32'h24);
      end
    join
    repeat (8) @(posedge ref_clk_in);
    pins(7'h11, 1'b1, 1'b1, 1'b0);
  endtask

  task automatic close_out();
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    ref_clk_in = 1'b0;
    reset_n_in = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    repeat (16) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    @(posedge ref_clk_in);
    t_reset();
    t_power();
    t_load();
    t_stray();
    close_out();
  end
endmodule
